// ==== shared/flash_seq_consts.vh ====
// constants for the flash programming sequencer
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH
`define OFS_DATA 8'he2
`define OFS_ADDR_HIGH 8'he3
`define OFS_ADDR_LOW 8'he4
`define OFS_MODE 8'hf5
`define OFS_CMD 8'he6
`define OFS_CTRL 8'he7
`define OFS_LOW_BOUND 8'hf6
`define OFS_STATUS 8'hf7
`define RST_DATA 8'hff
`define RST_ADDR 8'h00
`define RST_MODE 5'h00
`define RST_CTRL 8'h00
`define CTRL_ENABLE 7
`define CTRL_BOOT_SEL 6
`define CTRL_SOFT_RST 5
`define CTRL_FAIL 4
`define SOFT_BOOT_CODE 3'h7
`define KEY_FIRST 8'h46
`define KEY_SECOND 8'hb9
`define MODE_STANDBY 5'h00
`define MODE_READ 5'h01
`define MODE_PROGRAM 5'h02
`define MODE_ERASE 5'h03
`define NO_LOADER_HIGH 16'h3dff
`define FLASH_TIMEOUT_CYCLES 16'h0fff
`endif

// ==== logic/flash_seq.v ====
// flash programming sequencer: trigger, stall, range check, boot control
// Overview of operation
// - 111 written from application memory reboots loader
// - loader boot needs a nonempty loader region
// - loader fetches offset by loader start
// - stall cpu; hold interrupts pending meanwhile
// - release cpu; service still-set pending interrupts
// - freeze cpu, resume at next instruction
// - loader mode ignores targets past data region
// - application mode limited to data region
// - with loader: bounds from loader start
// - without loader: upper bound fixed 0x3dff
// - low bound setting loaded from configuration
// - application code cannot alter loader region
// - start needs 46 then b9 with enable
// - mode codes: standby read program erase
// - boot select picks loader on a soft reset, if a loader is present
// - fail flag set on failure, cleared otherwise
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_consts.vh"
module flash_seq #(
   parameter ADDR_W = 16,
   parameter [15:0] TIMEOUT = `FLASH_TIMEOUT_CYCLES
) (
   input wire clk,
   input wire nrst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire [ADDR_W-1:0] loader_start,
   input wire loader_present,
   input wire hw_loader_boot_option,
   input wire hw_loader_boot_on_ext_reset_option,
   input wire [7:0] cfg_low_bound,
   input wire cfg_load,
   input wire running_in_loader,
   input wire [ADDR_W-1:0] fetch_addr,
   output reg [ADDR_W-1:0] fetch_phys_addr,
   input wire [7:0] irq_req,
   output reg [7:0] irq_pending,
   output reg [7:0] irq_service,
   output wire cpu_freeze,
   output reg soft_reset,
   output reg boot_from_loader,
   output reg flash_req,
   output reg [1:0] flash_op,
   output reg [ADDR_W-1:0] flash_addr,
   output reg [7:0] flash_wdata,
   input wire flash_done,
   input wire flash_ok,
   input wire [7:0] flash_rdata
);
   localparam S_IDLE = 3'b001;
   localparam S_BUSY = 3'b010;
   localparam S_END = 3'b100;
   reg [1:0] rst_sync;
   wire rst_n = rst_sync[1];
   reg [2:0] state;
   reg [7:0] flash_data_port;
   reg [7:0] flash_addr_high;
   reg [7:0] flash_addr_low;
   reg [4:0] flash_op_mode_select;
   reg flash_access_enable;
   reg soft_boot_select;
   reg command_fail_flag;
   reg [2:0] wait_sel;
   reg [7:0] data_region_low_bound;
   reg key_seen;
   reg [15:0] timer;
   reg [ADDR_W-1:0] region_high;
   reg [ADDR_W-1:0] region_low;
   reg [ADDR_W-1:0] size_bytes;
   wire [ADDR_W-1:0] target = {flash_addr_high, flash_addr_low};
   wire mode_valid = (flash_op_mode_select == `MODE_READ) ||
      (flash_op_mode_select == `MODE_PROGRAM) || (flash_op_mode_select == `MODE_ERASE);
   wire cmd_wr = reg_wr && (reg_addr == `OFS_CMD);
   wire trigger = cmd_wr && key_seen && (reg_wdata == `KEY_SECOND)
      && flash_access_enable;
   reg in_range;
   function in_window;
      input [ADDR_W-1:0] a;
      input [ADDR_W-1:0] lo;
      input [ADDR_W-1:0] hi;
      begin
         in_window = (a >= lo) && (a <= hi);
      end
   endfunction
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   // size in 256-byte units from the low bound setting
   always @* begin
      size_bytes = {data_region_low_bound, 8'h00};
      if (loader_present) begin
         region_high = loader_start - 1'b1;
         region_low = loader_start - size_bytes;
      end else begin
         region_high = `NO_LOADER_HIGH;
         region_low = `NO_LOADER_HIGH - size_bytes + 1'b1;
      end
      if (running_in_loader) begin
         in_range = target <= region_high;
      end else begin
         in_range = in_window(target, region_low, region_high);
      end
   end
   // loader code linked at zero, relocated on fetch
   always @* begin
      if (running_in_loader && loader_present) begin
         fetch_phys_addr = fetch_addr + loader_start;
      end else begin
         fetch_phys_addr = fetch_addr;
      end
   end
   // stall is a freeze, not idle: pc is simply held
   assign cpu_freeze = (state != S_IDLE);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
         flash_data_port <= `RST_DATA;
         flash_addr_high <= `RST_ADDR;
         flash_addr_low <= `RST_ADDR;
         flash_op_mode_select <= `RST_MODE;
         flash_access_enable <= 1'b0;
         soft_boot_select <= 1'b0;
         command_fail_flag <= 1'b0;
         wait_sel <= 3'h0;
         data_region_low_bound <= 8'h00;
         key_seen <= 1'b0;
         timer <= 16'h0000;
         soft_reset <= 1'b0;
         boot_from_loader <= 1'b0;
         flash_req <= 1'b0;
         flash_op <= 2'h0;
         flash_addr <= {ADDR_W{1'b0}};
         flash_wdata <= 8'h00;
         irq_pending <= 8'h00;
         irq_service <= 8'h00;
         reg_rdata <= 8'h00;
      end else begin
         soft_reset <= 1'b0;
         irq_service <= 8'h00;
         if (cfg_load) begin
            data_region_low_bound <= cfg_low_bound;
         end
         if (cmd_wr) begin
            // any other cmd byte drops the half-seen key
            key_seen <= (reg_wdata == `KEY_FIRST);
         end
         if (reg_wr && state == S_IDLE) begin
            case (reg_addr)
               `OFS_DATA: flash_data_port <= reg_wdata;
               `OFS_ADDR_HIGH: flash_addr_high <= reg_wdata;
               `OFS_ADDR_LOW: flash_addr_low <= reg_wdata;
               `OFS_MODE: flash_op_mode_select <= reg_wdata[4:0];
               `OFS_CTRL: begin
                  flash_access_enable <= reg_wdata[`CTRL_ENABLE];
                  soft_boot_select <= reg_wdata[`CTRL_BOOT_SEL];
                  command_fail_flag <= reg_wdata[`CTRL_FAIL];
                  wait_sel <= reg_wdata[2:0];
                  if (reg_wdata[7:5] == `SOFT_BOOT_CODE && !running_in_loader) begin
                     soft_reset <= loader_present;
                     boot_from_loader <= loader_present;
                  end else if (reg_wdata[`CTRL_SOFT_RST]) begin
                     soft_reset <= 1'b1;
                     boot_from_loader <= reg_wdata[`CTRL_BOOT_SEL]
                        && loader_present;
                  end
               end
               default: ;
            endcase
         end
         case (state)
            S_IDLE: begin
               if (trigger) begin
                  if (mode_valid && in_range) begin
                     state <= S_BUSY;
                     flash_req <= 1'b1;
                     flash_op <= flash_op_mode_select[1:0];
                     flash_addr <= target;
                     flash_wdata <= flash_data_port;
                     timer <= TIMEOUT;
                  end else begin
                     // one frozen cycle, no flash access
                     state <= S_END;
                     command_fail_flag <= 1'b1;
                  end
               end
            end
            S_BUSY: begin
               flash_req <= 1'b0;
               irq_pending <= irq_pending | irq_req;
               timer <= timer - 16'h0001;
               if (flash_done || timer == 16'h0000) begin
                  state <= S_END;
                  command_fail_flag <= !(flash_done && flash_ok);
                  if (flash_done && flash_ok && flash_op == `MODE_READ) begin
                     flash_data_port <= flash_rdata;
                  end
               end
            end
            S_END: begin
               state <= S_IDLE;
               irq_service <= irq_pending & irq_req;
               irq_pending <= 8'h00;
            end
            default: state <= S_IDLE;
         endcase
         if (reg_rd) begin
            case (reg_addr)
               `OFS_DATA: reg_rdata <= flash_data_port;
               `OFS_ADDR_HIGH: reg_rdata <= flash_addr_high;
               `OFS_ADDR_LOW: reg_rdata <= flash_addr_low;
               `OFS_MODE: reg_rdata <= {3'h0, flash_op_mode_select};
               `OFS_CTRL: reg_rdata <= {flash_access_enable, soft_boot_select, 1'b0,
                  command_fail_flag, 1'b0, wait_sel};
               `OFS_LOW_BOUND: reg_rdata <= data_region_low_bound;
               `OFS_STATUS: reg_rdata <= {5'h00, hw_loader_boot_on_ext_reset_option,
                  hw_loader_boot_option, cpu_freeze};
               default: reg_rdata <= 8'h00;
            endcase
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/flash_seq_monitor.sv ====
// port checker for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_seq_monitor #(parameter ADDR_W = 16) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [7:0] cfg_low_bound,
   input wire logic cfg_load,
   input wire logic [ADDR_W-1:0] loader_start,
   input wire logic loader_present,
   input wire logic running_in_loader,
   input wire logic [ADDR_W-1:0] fetch_addr,
   input wire logic [ADDR_W-1:0] fetch_phys_addr,
   input wire logic [7:0] irq_service,
   input wire logic cpu_freeze,
   input wire logic soft_reset,
   input wire logic flash_req,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic flash_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic key, en;
   logic [7:0] lb;
   wire cmd_any = reg_wr && reg_addr == 8'he6;
   wire cw = cmd_any && !cpu_freeze;
   wire kw = cw && reg_wdata == 8'hb9 && key && en;
   wire sw = reg_wr && reg_addr == 8'he7 && reg_wdata[7:5] == 3'h7 && !running_in_loader;
   wire [ADDR_W-1:0] hi = loader_present ? loader_start - 1'b1 : 16'h3dff;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         key <= 1'b0;
         en <= 1'b0;
         lb <= 8'h00;
      end else begin
         if (cmd_any) key <= reg_wdata == 8'h46;
         if (reg_wr && reg_addr == 8'he7 && !cpu_freeze) en <= reg_wdata[7];
         if (cfg_load) lb <= cfg_low_bound;
      end
   end
   sequence s_release; cpu_freeze ##1 !cpu_freeze; endsequence
   property p_trig; kw |=> cpu_freeze; endproperty
   a_trig: assert property (p_trig) else $error("no stall");
   property p_nostart; cw && !kw |=> !cpu_freeze; endproperty
   a_nostart: assert property (p_nostart) else $error("bad stall");
   property p_hold; flash_done && cpu_freeze |=> s_release; endproperty
   a_hold: assert property (p_hold) else $error("release");
   property p_svc; irq_service != 8'h00 |-> !cpu_freeze && $past(cpu_freeze); endproperty
   a_svc: assert property (p_svc) else $error("service");
   property p_fetch; running_in_loader && loader_present |->
      fetch_phys_addr == fetch_addr + loader_start; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch");
   property p_soft; sw && loader_present && !cpu_freeze |=> soft_reset; endproperty
   a_soft: assert property (p_soft) else $error("soft reset");
   property p_noload; sw && !loader_present |=> !soft_reset; endproperty
   a_noload: assert property (p_noload) else $error("no loader");
   property p_range; flash_req |-> flash_addr <= hi
      && (running_in_loader || flash_addr >= hi - {lb, 8'h00} + 1'b1); endproperty
   a_range: assert property (p_range) else $error("range");
endmodule
bind flash_seq flash_seq_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk, .nrst, .reg_addr, .reg_wdata,
   .reg_wr, .cfg_low_bound, .cfg_load, .loader_start, .loader_present, .running_in_loader,
   .fetch_addr, .fetch_phys_addr, .irq_service, .cpu_freeze, .soft_reset, .flash_req,
   .flash_addr, .flash_done);
`default_nettype wire

// ==== sim/flash_model.sv ====
// behavioural flash array
`timescale 1ns/1ps
`default_nettype none
module flash_model (
   input wire logic clk,
   input wire logic flash_req,
   input wire logic [1:0] flash_op,
   input wire logic [15:0] flash_addr,
   input wire logic [7:0] flash_wdata,
   input wire logic slow,
   output logic flash_done,
   output logic [7:0] flash_rdata
);
   logic [7:0] mem [int];
   logic [7:0] q = 8'h00, w;
   logic [15:0] a;
   logic [1:0] o;
   int wt = -1;
   initial flash_done = 1'b0;
   // data only valid with done; inverted otherwise so late sampling shows
   assign flash_rdata = flash_done ? q : ~q;
   always @(posedge clk) begin
      flash_done <= 1'b0;
      if (flash_req) begin
         a <= flash_addr;
         o <= flash_op;
         w <= flash_wdata;
         wt <= slow ? 9 : 1;
      end else if (wt > 0) wt <= wt - 1;
      else if (wt == 0) begin
         wt <= -1;
         flash_done <= 1'b1;
         if (o == 2'd1) q <= mem.exists(a) ? mem[a] : 8'hff;
         if (o == 2'd2) mem[a] = (mem.exists(a) ? mem[a] : 8'hff) & w;
         if (o == 2'd3) for (int k = 0; k < 512; k++) mem[{a[15:9], 9'h000} + k] = 8'hff;
      end
   end
endmodule
`default_nettype wire

// ==== sim/isp_iap_flash_sequencer_bench.sv ====
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module isp_iap_flash_sequencer_bench;
   logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cfg_load = 1'b0, bad = 1'b0;
   logic loader_present = 1'b1, running_in_loader = 1'b0, flash_ok = 1'b1, slow = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cfg_low_bound = 8'h04, irq_req = 8'h00, q, d, s;
   logic [15:0] loader_start = 16'h3800, fetch_addr = 16'h0000, a;
   wire [7:0] reg_rdata, irq_pending, irq_service, flash_wdata, flash_rdata;
   wire [15:0] fetch_phys_addr, flash_addr;
   wire [1:0] flash_op;
   wire cpu_freeze, soft_reset, boot_from_loader, flash_req, flash_done;
   int n_mismatch = 0, compares = 0, cyc = 0;
   flash_seq #(.TIMEOUT(16'h0014)) u_flash_seq (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .loader_start, .loader_present, .hw_loader_boot_option(1'b0),
      .hw_loader_boot_on_ext_reset_option(1'b0), .cfg_low_bound, .cfg_load, .running_in_loader,
      .fetch_addr, .fetch_phys_addr, .irq_req, .irq_pending, .irq_service, .cpu_freeze,
      .soft_reset, .boot_from_loader, .flash_req, .flash_op, .flash_addr, .flash_wdata,
      .flash_done, .flash_ok, .flash_rdata);
   flash_model u_flash_model (.clk, .flash_req, .flash_op, .flash_addr, .flash_wdata, .slow,
      .flash_done, .flash_rdata);
   always #50 clk = ~clk;
   task automatic test_done;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      fetch_addr <= 16'($urandom);
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_mismatch++;
         test_done();
      end
   end
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   function automatic logic ok_at(input logic [15:0] ad);
      logic [15:0] hi;
      hi = loader_present ? loader_start - 16'h0001 : 16'h3dff;
      return ad <= hi && (running_in_loader || ad >= hi - 16'h03ff);
   endfunction
   task automatic go(input logic [1:0] m, input logic [15:0] ad, input logic [7:0] v, er);
      logic ok;
      int t;
      ok = ok_at(ad);
      flash_ok <= !(bad && m == 2'd3);
      wr(8'hf5, {6'h00, m});
      wr(8'he3, ad[15:8]);
      wr(8'he4, ad[7:0]);
      wr(8'he2, v);
      wr(8'he6, 8'h46);
      wr(8'he6, 8'hb9);
      #1 chk("stall", cpu_freeze, 8'h01);
      s = 8'h00;
      t = 0;
      do begin
         @(posedge clk);
         #1 s = s | irq_service;
         t++;
      end while (cpu_freeze === 1'b1 && t < 60);
      if (cpu_freeze !== 1'b0) n_mismatch++;
      if (ok && !bad) chk("irq", s, irq_req);
      rd(8'he2);
      chk("data", q, (ok && m == 2'd1) ? er : v);
      rd(8'he7);
      chk("fail", q[4], !ok || (bad && m == 2'd3));
   endtask
   initial begin
      void'($urandom(32'h0d53));
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      cfg_load <= 1'b1;
      @(posedge clk);
      cfg_load <= 1'b0;
      rd(8'hf6);
      chk("bound", q, 8'h04);
      wr(8'h10, 8'h55);
      wr(8'he7, 8'h80);
      for (int i = 0; i < 8; i++) begin
         a = i[0] ? 16'($urandom_range(16'h3fff)) : 16'h3400 + 16'($urandom_range(16'h3ff));
         d = 8'($urandom);
         running_in_loader <= i[1];
         loader_present <= i < 6;
         slow <= i[2];
         bad <= i == 5;
         irq_req <= 8'($urandom);
         @(posedge clk);
         go(2'd3, a & 16'hfe00, 8'h00, 8'h00);
         go(2'd2, a, d, 8'h00);
         go(2'd1, a, 8'h5a, d);
      end
      loader_present <= 1'b1;
      running_in_loader <= 1'b0;
      wr(8'he6, 8'h46);
      wr(8'he6, 8'h00);
      wr(8'he6, 8'hb9);
      #1 chk("broken key", cpu_freeze, 8'h00);
      wr(8'he7, 8'h00);
      wr(8'he6, 8'h46);
      wr(8'he6, 8'hb9);
      #1 chk("disabled", cpu_freeze, 8'h00);
      wr(8'he7, 8'he0);
      #1 chk("soft reset", soft_reset, 8'h01);
      @(posedge clk);
      #1 chk("boot sel", boot_from_loader, 8'h01);
      loader_present <= 1'b0;
      wr(8'he7, 8'he0);
      #1 chk("no loader", soft_reset, 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
